//--- hw/ccid_pkg.sv
package ccid_pkg;

    // slice configurations, chosen statically by the surrounding design
    typedef enum logic [3:0] {
        UPPER_MID_COUNT_UP,
        UPPER_LSB_UP_INVERTED_ENABLE,
        DUAL_LSB_COUNT_UP,
        LOWER_MID_COUNT_DOWN,
        DUAL_MID_COUNT_DOWN,
        UPPER_LSB_DOWN_FIXED,
        UPPER_LSB_DOWN_OPERAND_ENABLE,
        UPPER_MID_COUNT_DOWN,
        UPPER_LSB_DOWN_INVERTED_ENABLE,
        DUAL_LSB_COUNT_DOWN,
        LOWER_MID_UPDOWN,
        DUAL_MID_UPDOWN,
        UPPER_LSB_UPDOWN_FIXED,
        UPPER_LSB_UPDOWN_OPERAND_CARRY,
        UPPER_MID_UPDOWN,
        DUAL_LSB_UPDOWN
    } ccid_mode_t;

    // where the lower stage carry comes from
    typedef enum logic [2:0] {
        LC_ZERO, LC_CHAIN, LC_OPERAND, LC_NOT_DIR, LC_DOWN, LC_UPDOWN
    } ccid_lcarry_t;

    // what the lower function generator computes
    typedef enum logic [1:0] {
        LF_IDLE, LF_NOT_OPERAND, LF_DOWN, LF_UPDOWN
    } ccid_lfn_t;

    // what the upper function generator computes
    typedef enum logic [2:0] {
        UF_IDLE, UF_NOT_OPERAND, UF_UP, UF_DOWN, UF_UPDOWN
    } ccid_ufn_t;

    // how the upper carry logic forms the slice carry out
    typedef enum logic [2:0] {
        UC_PASS, UC_OPERAND, UC_UP, UC_DOWN, UC_UPDOWN
    } ccid_ucarry_t;

    // value an unused generator output is held at
    localparam logic IDLE_RESULT = 1'b0;
    // reset value of the sampled copies
    localparam logic SNAP_RST = 1'b0;

endpackage : ccid_pkg

//--- hw/ccid_stage_if.sv
`timescale 1ns/1ps

// carries the direction control and the lower stage carry between generators
interface ccid_stage_if;
    logic directionSelect;
    logic lowerStageCarry;

    modport top_mp (output directionSelect);
    modport lower_mp (input directionSelect, output lowerStageCarry);
    modport upper_mp (input directionSelect, input lowerStageCarry);
endinterface : ccid_stage_if

//--- hw/ccid_lower_stage.sv
`timescale 1ns/1ps

module ccid_lower_stage (
    input wire logic lowerOperandIn,
    input wire logic carryChainIn,
    input wire logic lowerCarryFeedIn,
    input wire logic feedFromChain,
    input wire ccid_pkg::ccid_lcarry_t carrySrc,
    input wire ccid_pkg::ccid_lfn_t lowerFn,
    ccid_stage_if.lower_mp link,
    output logic lowerResult
);
    import ccid_pkg::*;

    logic lowerCarryFeed;
    logic dir;

    // feed keeps its general input unless the chain claims it
    assign lowerCarryFeed = feedFromChain ? carryChainIn : lowerCarryFeedIn;
    assign dir = link.directionSelect;

    // lower stage carry selection
    always_comb begin
        case (carrySrc)
            LC_ZERO: link.lowerStageCarry = 1'b0;
            LC_CHAIN: link.lowerStageCarry = carryChainIn;
            LC_OPERAND: link.lowerStageCarry = lowerOperandIn;
            LC_NOT_DIR: link.lowerStageCarry = ~dir;
            LC_DOWN: link.lowerStageCarry = lowerOperandIn | carryChainIn;
            LC_UPDOWN: link.lowerStageCarry = (~dir & (lowerOperandIn | carryChainIn))
                | (dir & lowerOperandIn & carryChainIn);
            default: link.lowerStageCarry = 1'b0;
        endcase
    end

    // lower function generator
    always_comb begin
        case (lowerFn)
            LF_NOT_OPERAND: lowerResult = ~lowerOperandIn;
            LF_DOWN: lowerResult = ~(lowerOperandIn ^ lowerCarryFeed);
            LF_UPDOWN: lowerResult = (lowerOperandIn ^ lowerCarryFeed) ^ ~dir;
            default: lowerResult = IDLE_RESULT;
        endcase
    end

endmodule : ccid_lower_stage

//--- hw/ccid_upper_stage.sv
`timescale 1ns/1ps

module ccid_upper_stage (
    input wire logic upperOperandIn,
    input wire logic upperDirectionSelect,
    input wire logic upperCarryFeedIn,
    input wire logic feedFromLower,
    input wire ccid_pkg::ccid_ufn_t upperFn,
    input wire ccid_pkg::ccid_ucarry_t carryFn,
    ccid_stage_if.upper_mp link,
    output logic upperResult,
    output logic upperStageCarry
);
    import ccid_pkg::*;

    logic upperCarryFeed;
    logic carry;
    logic dir;

    // feed follows the lower stage carry in chained modes
    assign upperCarryFeed = feedFromLower ? link.lowerStageCarry : upperCarryFeedIn;
    assign carry = link.lowerStageCarry;
    assign dir = link.directionSelect;

    // upper function generator
    always_comb begin
        case (upperFn)
            UF_NOT_OPERAND: upperResult = ~upperOperandIn;
            UF_UP: upperResult = upperOperandIn ^ upperCarryFeed;
            UF_DOWN: upperResult = ~(upperOperandIn ^ upperCarryFeed);
            UF_UPDOWN: upperResult = (upperOperandIn ^ upperCarryFeed) ^ ~upperDirectionSelect;
            default: upperResult = IDLE_RESULT;
        endcase
    end

    // upper carry logic; direction always comes from the lower side input
    always_comb begin
        case (carryFn)
            UC_PASS: upperStageCarry = carry;
            UC_OPERAND: upperStageCarry = upperOperandIn;
            UC_UP: upperStageCarry = carry & upperOperandIn;
            UC_DOWN: upperStageCarry = upperOperandIn | carry;
            UC_UPDOWN: upperStageCarry = (~dir & (upperOperandIn | carry))
                | (dir & upperOperandIn & carry);
            default: upperStageCarry = carry;
        endcase
    end

endmodule : ccid_upper_stage

//--- hw/ccid_slice.sv
// Operation
// - upper middle increment: carry from chain
// - upper LSB increment, inverted direction enable
// - dual LSB increment, always enabled
// - lower middle decrement, carry passes out
// - dual middle decrement through both generators
// - fixed LSB: zero carry, invert upper
// - upper LSB decrement, lower operand enables
// - upper middle decrement: carry from chain
// - upper LSB decrement, inverted direction enable
// - dual LSB decrement, always enabled
// - lower middle up/down, carry passes out
// - dual middle up/down through both generators
// - upper LSB up/down, lower operand carry
// - upper middle up/down uses direction
// - dual LSB up/down, always enabled
// - upper LSB modes feed the upper generator from the lower stage carry, not its general input
`timescale 1ns/1ps

module ccid_slice (
    input wire logic clk_sys,
    input wire logic rst,
    input wire ccid_pkg::ccid_mode_t sliceMode,
    input wire logic lowerOperandIn,
    input wire logic upperOperandIn,
    input wire logic directionSelect,
    input wire logic upperDirectionSelect,
    input wire logic lowerCarryFeedIn,
    input wire logic upperCarryFeedIn,
    input wire logic carryChainIn,
    output logic lowerResult,
    output logic upperResult,
    output logic carryChainOut,
    output logic countEndFlag,
    output logic lowerResultQ,
    output logic upperResultQ,
    output logic carryChainOutQ
);
    import ccid_pkg::*;

    ccid_lcarry_t carrySrc;
    ccid_lfn_t lowerFn;
    ccid_ufn_t upperFn;
    ccid_ucarry_t carryFn;
    logic feedFromChain;
    logic feedFromLower;
    logic countEndEn;
    logic upperStageCarry;
    logic lowerResultRaw;
    logic upperResultRaw;

    ccid_stage_if link ();

    // direction reaches both stage carries through one wire
    assign link.directionSelect = directionSelect;

    // configuration decode; mode is static so no glitch concern here
    always_comb begin
        carrySrc = LC_ZERO;
        lowerFn = LF_IDLE;
        upperFn = UF_IDLE;
        carryFn = UC_PASS;
        feedFromChain = 1'b0;
        feedFromLower = 1'b0;
        countEndEn = 1'b0;
        case (sliceMode)
            // middle bit of an incrementer, lower generator left free
            UPPER_MID_COUNT_UP: begin
                carrySrc = LC_CHAIN;
                lowerFn = LF_IDLE;
                upperFn = UF_UP;
                carryFn = UC_UP;
                feedFromChain = 1'b0;
                feedFromLower = 1'b1;
                countEndEn = 1'b0;
            end
            // lsb of an incrementer, direction pin low enables it
            UPPER_LSB_UP_INVERTED_ENABLE: begin
                carrySrc = LC_NOT_DIR;
                lowerFn = LF_IDLE;
                upperFn = UF_UP;
                carryFn = UC_UP;
                feedFromChain = 1'b0;
                feedFromLower = 1'b1;
                countEndEn = 1'b0;
            end
            // two bottom bits, carry-in tied active
            DUAL_LSB_COUNT_UP: begin
                carrySrc = LC_OPERAND;
                lowerFn = LF_NOT_OPERAND;
                upperFn = UF_UP;
                carryFn = UC_UP;
                feedFromChain = 1'b0;
                feedFromLower = 1'b1;
                countEndEn = 1'b0;
            end
            // middle bit of a decrementer in the lower generator only
            LOWER_MID_COUNT_DOWN: begin
                carrySrc = LC_DOWN;
                lowerFn = LF_DOWN;
                upperFn = UF_IDLE;
                carryFn = UC_PASS;
                feedFromChain = 1'b1;
                feedFromLower = 1'b0;
                countEndEn = 1'b1;
            end
            // two middle bits of a decrementer
            DUAL_MID_COUNT_DOWN: begin
                carrySrc = LC_DOWN;
                lowerFn = LF_DOWN;
                upperFn = UF_DOWN;
                carryFn = UC_DOWN;
                feedFromChain = 1'b1;
                feedFromLower = 1'b1;
                countEndEn = 1'b0;
            end
            // one lsb mapping serves down and up/down counters
            UPPER_LSB_DOWN_FIXED,
            UPPER_LSB_UPDOWN_FIXED: begin
                carrySrc = LC_ZERO;
                lowerFn = LF_IDLE;
                upperFn = UF_NOT_OPERAND;
                carryFn = UC_OPERAND;
                feedFromChain = 1'b0;
                feedFromLower = 1'b1;
                countEndEn = 1'b0;
            end
            // lsb of a decrementer, lower operand low enables it
            UPPER_LSB_DOWN_OPERAND_ENABLE: begin
                carrySrc = LC_OPERAND;
                lowerFn = LF_IDLE;
                upperFn = UF_DOWN;
                carryFn = UC_DOWN;
                feedFromChain = 1'b0;
                feedFromLower = 1'b1;
                countEndEn = 1'b0;
            end
            // middle bit of a decrementer, lower generator left free
            UPPER_MID_COUNT_DOWN: begin
                carrySrc = LC_CHAIN;
                lowerFn = LF_IDLE;
                upperFn = UF_DOWN;
                carryFn = UC_DOWN;
                feedFromChain = 1'b0;
                feedFromLower = 1'b1;
                countEndEn = 1'b0;
            end
            // lsb of a decrementer, direction pin high enables it
            UPPER_LSB_DOWN_INVERTED_ENABLE: begin
                carrySrc = LC_NOT_DIR;
                lowerFn = LF_IDLE;
                upperFn = UF_DOWN;
                carryFn = UC_DOWN;
                feedFromChain = 1'b0;
                feedFromLower = 1'b1;
                countEndEn = 1'b0;
            end
            // two bottom bits of a decrementer; (c & ~op) | op folds to op | c
            DUAL_LSB_COUNT_DOWN: begin
                carrySrc = LC_OPERAND;
                lowerFn = LF_NOT_OPERAND;
                upperFn = UF_DOWN;
                carryFn = UC_DOWN;
                feedFromChain = 1'b0;
                feedFromLower = 1'b1;
                countEndEn = 1'b0;
            end
            // one up/down bit in the lower generator, carry straight out
            LOWER_MID_UPDOWN: begin
                carrySrc = LC_UPDOWN;
                lowerFn = LF_UPDOWN;
                upperFn = UF_IDLE;
                carryFn = UC_PASS;
                feedFromChain = 1'b1;
                feedFromLower = 1'b0;
                countEndEn = 1'b1;
            end
            // two up/down middle bits; both direction pins must match
            DUAL_MID_UPDOWN: begin
                carrySrc = LC_UPDOWN;
                lowerFn = LF_UPDOWN;
                upperFn = UF_UPDOWN;
                carryFn = UC_UPDOWN;
                feedFromChain = 1'b1;
                feedFromLower = 1'b1;
                countEndEn = 1'b0;
            end
            // up/down lsb, lower operand is the carry in
            UPPER_LSB_UPDOWN_OPERAND_CARRY: begin
                carrySrc = LC_OPERAND;
                lowerFn = LF_IDLE;
                upperFn = UF_UPDOWN;
                carryFn = UC_UPDOWN;
                feedFromChain = 1'b0;
                feedFromLower = 1'b1;
                countEndEn = 1'b0;
            end
            // up/down middle bit; carry still reads the lower direction pin
            UPPER_MID_UPDOWN: begin
                carrySrc = LC_CHAIN;
                lowerFn = LF_IDLE;
                upperFn = UF_UPDOWN;
                carryFn = UC_UPDOWN;
                feedFromChain = 1'b0;
                feedFromLower = 1'b1;
                countEndEn = 1'b0;
            end
            // two bottom up/down bits, always enabled
            DUAL_LSB_UPDOWN: begin
                carrySrc = LC_OPERAND;
                lowerFn = LF_NOT_OPERAND;
                upperFn = UF_UPDOWN;
                carryFn = UC_UPDOWN;
                feedFromChain = 1'b0;
                feedFromLower = 1'b1;
                countEndEn = 1'b0;
            end
            default: begin
                carrySrc = LC_CHAIN;
                lowerFn = LF_IDLE;
                upperFn = UF_IDLE;
                carryFn = UC_PASS;
                feedFromChain = 1'b0;
                feedFromLower = 1'b0;
                countEndEn = 1'b0;
            end
        endcase
    end

    // lower generator and its carry
    ccid_lower_stage lowerStage (
        .lowerOperandIn(lowerOperandIn),
        .carryChainIn(carryChainIn),
        .lowerCarryFeedIn(lowerCarryFeedIn),
        .feedFromChain(feedFromChain),
        .carrySrc(carrySrc),
        .lowerFn(lowerFn),
        .link(link.lower_mp),
        .lowerResult(lowerResultRaw)
    );

    // upper generator and the slice carry out
    ccid_upper_stage upperStage (
        .upperOperandIn(upperOperandIn),
        .upperDirectionSelect(upperDirectionSelect),
        .upperCarryFeedIn(upperCarryFeedIn),
        .feedFromLower(feedFromLower),
        .upperFn(upperFn),
        .carryFn(carryFn),
        .link(link.upper_mp),
        .upperResult(upperResultRaw),
        .upperStageCarry(upperStageCarry)
    );

    // the chain must ripple within one period, so no flop sits in it
    assign lowerResult = lowerResultRaw;
    assign upperResult = upperResultRaw;
    assign carryChainOut = upperStageCarry;

    // terminal count from the lower carry when the upper side is free
    assign countEndFlag = countEndEn & link.lowerStageCarry;

    // sampled results, handy for building a counter register around the slice
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lowerResultQ <= SNAP_RST;
            upperResultQ <= SNAP_RST;
        end else begin
            lowerResultQ <= lowerResultRaw;
            upperResultQ <= upperResultRaw;
        end
    end

    // sampled carry out, lets a timing-relaxed user read the chain a cycle late
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            carryChainOutQ <= SNAP_RST;
        end else begin
            carryChainOutQ <= upperStageCarry;
        end
    end

endmodule : ccid_slice

//--- verification/ccid_nbr_model.sv
`timescale 1ns/1ps

// neighbouring logic: previous slice carry and one shared direction command
module ccid_nbr_model (
    input wire logic dirCmd,
    input wire logic prevCarry,
    output logic directionSelect,
    output logic upperDirectionSelect,
    output logic carryChainIn
);
    // one control net fans out to both generators, so they never disagree
    assign directionSelect = dirCmd;
    assign upperDirectionSelect = dirCmd;
    // carry of the previous slice handed straight on
    assign carryChainIn = prevCarry;
endmodule : ccid_nbr_model

//--- verification/ccid_slice_chk.sv
`timescale 1ns/1ps

module ccid_slice_chk (
    input wire logic clk_sys,
    input wire logic rst,
    input wire ccid_pkg::ccid_mode_t sliceMode,
    input wire logic lowerOperandIn,
    input wire logic upperOperandIn,
    input wire logic directionSelect,
    input wire logic carryChainIn,
    input wire logic lowerResult,
    input wire logic upperResult,
    input wire logic carryChainOut,
    input wire logic countEndFlag,
    input wire logic lowerResultQ,
    input wire logic upperResultQ,
    input wire logic carryChainOutQ
);
    import ccid_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // a sample is only owed once an edge has passed out of reset
    sequence s_run;
        !rst;
    endsequence
    sequence s_updown_mid;
        sliceMode == LOWER_MID_UPDOWN;
    endsequence

    // sampled copies trail the combinational outputs by one clock
    a_q_carry_lag: assert property (s_run |=> carryChainOutQ == $past(carryChainOut))
        else $error("registered carry does not trail carry out");
    a_q_result_lag: assert property (s_run |=> lowerResultQ == $past(lowerResult)
        && upperResultQ == $past(upperResult))
        else $error("registered results do not trail results");
    // nine counting modes, one assertion each, the two fixed lsb modes sharing one
    a_mid_up_carry: assert property (sliceMode == UPPER_MID_COUNT_UP |->
        carryChainOut == (carryChainIn & upperOperandIn)
        && upperResult == (upperOperandIn ^ carryChainIn))
        else $error("upper middle increment wrong");
    a_inv_enable_up: assert property (sliceMode == UPPER_LSB_UP_INVERTED_ENABLE |->
        carryChainOut == (!directionSelect && upperOperandIn) && lowerResult == 1'b0)
        else $error("inverted enable increment wrong");
    a_dual_lsb_up: assert property (sliceMode == DUAL_LSB_COUNT_UP |->
        lowerResult == !lowerOperandIn
        && carryChainOut == (lowerOperandIn & upperOperandIn))
        else $error("two lsb increment wrong");
    a_tc_flag_pass: assert property (sliceMode == LOWER_MID_COUNT_DOWN |->
        carryChainOut == (lowerOperandIn | carryChainIn)
        && countEndFlag == carryChainOut && upperResult == 1'b0)
        else $error("lower decrement carry or flag wrong");
    a_dual_mid_down: assert property (sliceMode == DUAL_MID_COUNT_DOWN |->
        carryChainOut == (upperOperandIn | lowerOperandIn | carryChainIn))
        else $error("two bit decrement carry wrong");
    a_fixed_lsb: assert property ((sliceMode == UPPER_LSB_DOWN_FIXED
        || sliceMode == UPPER_LSB_UPDOWN_FIXED) |->
        upperResult == !upperOperandIn && carryChainOut == upperOperandIn)
        else $error("fixed lsb mapping wrong");
    a_operand_enable: assert property (sliceMode == UPPER_LSB_DOWN_OPERAND_ENABLE |->
        carryChainOut == (lowerOperandIn | upperOperandIn))
        else $error("operand enable decrement carry wrong");
    a_updown_carry: assert property (s_updown_mid |-> countEndFlag == carryChainOut
        && carryChainOut == ((!directionSelect && (lowerOperandIn || carryChainIn))
        || (directionSelect && lowerOperandIn && carryChainIn)))
        else $error("lower up down carry wrong");
endmodule : ccid_slice_chk

bind ccid_slice ccid_slice_chk u_chk (.clk_sys(clk_sys), .rst(rst), .sliceMode(sliceMode),
    .lowerOperandIn(lowerOperandIn), .upperOperandIn(upperOperandIn),
    .directionSelect(directionSelect), .carryChainIn(carryChainIn),
    .lowerResult(lowerResult), .upperResult(upperResult), .carryChainOut(carryChainOut),
    .countEndFlag(countEndFlag), .lowerResultQ(lowerResultQ), .upperResultQ(upperResultQ),
    .carryChainOutQ(carryChainOutQ));

//--- verification/tb.sv
`timescale 1ns/1ps

module tb;
    import ccid_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    ccid_mode_t sliceMode = UPPER_MID_COUNT_UP;
    logic lowerOperandIn = 1'b0;
    logic upperOperandIn = 1'b0;
    logic lowerCarryFeedIn = 1'b0;
    logic upperCarryFeedIn = 1'b0;
    logic dirCmd = 1'b0;
    logic prevCarry = 1'b0;
    logic directionSelect, upperDirectionSelect, carryChainIn;
    logic lowerResult, upperResult, carryChainOut, countEndFlag;
    logic lowerResultQ, upperResultQ, carryChainOutQ;
    int n_mismatch = 0;
    int tests_run = 0;

    // 40 MHz
    always #12.5 clk_sys = ~clk_sys;

    ccid_nbr_model u_nbr (.dirCmd(dirCmd), .prevCarry(prevCarry),
        .directionSelect(directionSelect), .upperDirectionSelect(upperDirectionSelect),
        .carryChainIn(carryChainIn));

    ccid_slice dut (.clk_sys(clk_sys), .rst(rst), .sliceMode(sliceMode),
        .lowerOperandIn(lowerOperandIn), .upperOperandIn(upperOperandIn),
        .directionSelect(directionSelect), .upperDirectionSelect(upperDirectionSelect),
        .lowerCarryFeedIn(lowerCarryFeedIn), .upperCarryFeedIn(upperCarryFeedIn),
        .carryChainIn(carryChainIn), .lowerResult(lowerResult), .upperResult(upperResult),
        .carryChainOut(carryChainOut), .countEndFlag(countEndFlag),
        .lowerResultQ(lowerResultQ), .upperResultQ(upperResultQ),
        .carryChainOutQ(carryChainOutQ));

    // reference slice: {lower, upper, carry out, count end}, directions tied together
    function automatic logic [3:0] slice_ref(ccid_mode_t m, logic lo, logic hi, logic d,
        logic ci);
        logic c, rl;
        c = lo;
        rl = 1'b0;
        case (m)
            UPPER_MID_COUNT_UP, UPPER_MID_COUNT_DOWN, UPPER_MID_UPDOWN: c = ci;
            UPPER_LSB_UP_INVERTED_ENABLE, UPPER_LSB_DOWN_INVERTED_ENABLE: c = ~d;
            LOWER_MID_COUNT_DOWN, DUAL_MID_COUNT_DOWN: c = lo | ci;
            LOWER_MID_UPDOWN, DUAL_MID_UPDOWN: c = (~d & (lo | ci)) | (d & lo & ci);
            UPPER_LSB_DOWN_FIXED, UPPER_LSB_UPDOWN_FIXED: c = 1'b0;
            default: c = lo;
        endcase
        case (m)
            DUAL_LSB_COUNT_UP, DUAL_LSB_COUNT_DOWN, DUAL_LSB_UPDOWN: rl = ~lo;
            LOWER_MID_COUNT_DOWN, DUAL_MID_COUNT_DOWN: rl = ~(lo ^ ci);
            LOWER_MID_UPDOWN, DUAL_MID_UPDOWN: rl = (lo ^ ci) ^ ~d;
            default: rl = 1'b0;
        endcase
        // carry-out kept in sum-of-products form, not the folded form of the logic
        case (m)
            UPPER_MID_COUNT_UP, UPPER_LSB_UP_INVERTED_ENABLE, DUAL_LSB_COUNT_UP:
                return {rl, hi ^ c, c & hi, 1'b0};
            LOWER_MID_COUNT_DOWN, LOWER_MID_UPDOWN: return {rl, 1'b0, c, c};
            UPPER_LSB_DOWN_FIXED, UPPER_LSB_UPDOWN_FIXED: return {rl, ~hi, hi, 1'b0};
            DUAL_MID_UPDOWN, UPPER_LSB_UPDOWN_OPERAND_CARRY, UPPER_MID_UPDOWN, DUAL_LSB_UPDOWN:
                return {rl, (hi ^ c) ^ ~d, (~d & ((c & ~hi) | hi)) | (d & hi & c), 1'b0};
            default: return {rl, ~(hi ^ c), (c & ~hi) | hi, 1'b0};
        endcase
    endfunction : slice_ref

    task automatic check_bit(input string what, input logic exp, input logic seen);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
        end
    endtask : check_bit

    // all 32 input patterns of one mode; entered and left just after a rising edge
    task automatic sweep(input ccid_mode_t m);
        logic [3:0] e;
        sliceMode = m;
        for (int i = 0; i < 32; i++) begin
            lowerOperandIn = i[0];
            upperOperandIn = i[1];
            dirCmd = i[2];
            prevCarry = i[3];
            lowerCarryFeedIn = i[4];
            upperCarryFeedIn = ~i[4];
            e = slice_ref(m, i[0], i[1], i[2], i[3]);
            @(negedge clk_sys);
            check_bit("lowerResult", e[3], lowerResult);
            check_bit("upperResult", e[2], upperResult);
            check_bit("carryChainOut", e[1], carryChainOut);
            check_bit("countEndFlag", e[0], countEndFlag);
            @(posedge clk_sys);
            #1;
            check_bit("lowerResultQ", e[3], lowerResultQ);
            check_bit("upperResultQ", e[2], upperResultQ);
            check_bit("carryChainOutQ", e[1], carryChainOutQ);
        end
    endtask : sweep

    task automatic t_count_up;
        sweep(UPPER_MID_COUNT_UP);
        sweep(UPPER_LSB_UP_INVERTED_ENABLE);
        sweep(DUAL_LSB_COUNT_UP);
    endtask : t_count_up

    task automatic t_count_down;
        sweep(LOWER_MID_COUNT_DOWN);
        sweep(DUAL_MID_COUNT_DOWN);
        sweep(UPPER_LSB_DOWN_OPERAND_ENABLE);
        sweep(UPPER_MID_COUNT_DOWN);
        sweep(UPPER_LSB_DOWN_INVERTED_ENABLE);
        sweep(DUAL_LSB_COUNT_DOWN);
    endtask : t_count_down

    task automatic t_fixed_lsb;
        sweep(UPPER_LSB_DOWN_FIXED);
        sweep(UPPER_LSB_UPDOWN_FIXED);
    endtask : t_fixed_lsb

    task automatic t_updown;
        sweep(LOWER_MID_UPDOWN);
        sweep(DUAL_MID_UPDOWN);
        sweep(UPPER_LSB_UPDOWN_OPERAND_CARRY);
        sweep(UPPER_MID_UPDOWN);
        sweep(DUAL_LSB_UPDOWN);
    endtask : t_updown

    // reset in mid-run clears only the sampled copies; counting down so all three are high
    task automatic t_reset_mid;
        logic [3:0] e;
        sliceMode = DUAL_MID_UPDOWN;
        lowerOperandIn = 1'b1;
        upperOperandIn = 1'b1;
        dirCmd = 1'b0;
        prevCarry = 1'b1;
        e = slice_ref(DUAL_MID_UPDOWN, 1'b1, 1'b1, 1'b0, 1'b1);
        @(posedge clk_sys);
        #1;
        rst = 1'b1;
        #2;
        check_bit("carryChainOutQ", 1'b0, carryChainOutQ);
        check_bit("upperResultQ", 1'b0, upperResultQ);
        check_bit("lowerResultQ", 1'b0, lowerResultQ);
        check_bit("carryChainOut", e[1], carryChainOut);
        @(posedge clk_sys);
        #1;
        rst = 1'b0;
        @(posedge clk_sys);
        #1;
        check_bit("carryChainOutQ", e[1], carryChainOutQ);
        check_bit("lowerResultQ", e[3], lowerResultQ);
        check_bit("upperResultQ", e[2], upperResultQ);
    endtask : t_reset_mid

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    // run needs about 525 cycles; give it ample room
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_mismatch++;
        end_of_test();
    end

    initial begin
        repeat (10) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        t_count_up();
        t_count_down();
        t_fixed_lsb();
        t_updown();
        t_reset_mid();
        end_of_test();
    end
endmodule : tb
